/* rtl/at8_pkg.sv */
// Package for the 8-bit asynchronous-capable timer with one compare channel.
// Assumes a 32-bit APB slave where each register takes one word at four times its index.
package at8_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_TIMER_CONTROL = 8'hB0;
  localparam logic [7:0] IDX_COUNTER_VALUE = 8'hB1;
  localparam logic [7:0] IDX_COMPARE_VALUE = 8'hB2;
  localparam logic [7:0] IDX_ASYNC_STATUS  = 8'hB6;
  localparam logic [7:0] IDX_IRQ_MASK      = 8'hB8;
  localparam logic [7:0] IDX_IRQ_FLAGS     = 8'hB9;
  localparam logic [7:0] IDX_GENERAL_CTL   = 8'hBA;
  localparam logic [7:0] IDX_PIN_CONTROL   = 8'hBB;

  // Field positions
  localparam int ASYNC_EXT_CLK_BIT   = 4;
  localparam int ASYNC_SELECT_BIT    = 3;
  localparam int BUSY_COUNTER_BIT    = 2;
  localparam int BUSY_COMPARE_BIT    = 1;
  localparam int BUSY_CONTROL_BIT    = 0;
  localparam int IRQ_COMPARE_BIT     = 1;
  localparam int IRQ_OVERFLOW_BIT    = 0;
  localparam int GEN_SYNC_MODE_BIT   = 7;
  localparam int GEN_PRESCALE_RST    = 1;
  localparam int PIN_DIR_BIT         = 0;
  localparam int PIN_GLOBAL_IE_BIT   = 1;

  // Reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // Counter limits
  localparam logic [7:0] CNT_MAX    = 8'hFF;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_ONE    = 8'h01;

  // Waveform modes, value is {upper, lower} mode bit
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_PHASE  = 2'h1;
  localparam logic [1:0] MODE_CLEAR_MATCH = 2'h2;
  localparam logic [1:0] MODE_FAST   = 2'h3;

  // Prescaler width, enough for the largest division of 1024
  localparam int PRESCALE_BITS = 10;

  // Timer control byte in its register layout
  typedef struct packed {
    logic       force_match;
    logic       wave_lo;
    logic [1:0] compare_output_mode;
    logic       wave_hi;
    logic [2:0] clock_select_bits;
  } at8_ctl_t;

  // Configuration handed to the waveform unit
  typedef struct packed {
    logic [1:0] waveform_mode_bits;
    logic [1:0] compare_output_mode;
    logic [7:0] compare_value;
  } at8_wave_cfg_t;

endpackage : at8_pkg

/* rtl/at8_prescaler.sv */
// Prescaler for the timer source clock, with the eight clock-select choices.
// Assumes src_tick is a one-cycle enable at the timer source rate.
`timescale 1ns/1ps
module at8_prescaler
  import at8_pkg::*;
#(
  parameter int WIDTH = PRESCALE_BITS
)
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       src_tick,
  input  wire logic       clear,
  input  wire logic [2:0] clock_select_bits,
  output logic            timer_tick
);

  typedef struct packed {
    logic [WIDTH-1:0] count;
  } at8_pre_state_t;

  at8_pre_state_t state_reg;
  at8_pre_state_t state_next;

  // Low bits that must all be one for a divided tick
  function automatic logic [WIDTH-1:0] tap_mask(input logic [2:0] sel);
    case (sel)
      3'h2:    tap_mask = WIDTH'(10'h007);
      3'h3:    tap_mask = WIDTH'(10'h01F);
      3'h4:    tap_mask = WIDTH'(10'h03F);
      3'h5:    tap_mask = WIDTH'(10'h07F);
      3'h6:    tap_mask = WIDTH'(10'h0FF);
      3'h7:    tap_mask = WIDTH'(10'h3FF);
      default: tap_mask = '0;
    endcase
  endfunction : tap_mask

  always_comb
  begin
    if (clock_select_bits == 3'h0)
    begin
      timer_tick = 1'b0;
    end
    else
    begin
      timer_tick = src_tick && ((state_reg.count & tap_mask(clock_select_bits))
                                == tap_mask(clock_select_bits));
    end
  end

  always_comb
  begin
    state_next = state_reg;
    if (clear)
    begin
      state_next.count = '0;
    end
    else if (src_tick)
    begin
      state_next.count = state_reg.count + WIDTH'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

endmodule : at8_prescaler

/* rtl/at8_waveform.sv */
// Compare unit and output waveform level for the single compare channel.
// Assumes counter, direction and tick come from the timer core in the same clock.
`timescale 1ns/1ps
module at8_waveform
  import at8_pkg::*;
(
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          timer_tick,
  input  wire logic [7:0]    counter_value,
  input  wire logic          count_up,
  input  wire logic          match_block,
  input  wire logic          force_match,
  input  wire at8_wave_cfg_t cfg,
  output logic               match,
  output logic               out_level
);

  typedef struct packed {
    logic level;
  } at8_wave_state_t;

  at8_wave_state_t state_reg;
  at8_wave_state_t state_next;
  logic            pwm_mode;
  logic            cmp_at_top;
  logic            at_top;

  assign out_level = state_reg.level;

  always_comb
  begin
    pwm_mode   = (cfg.waveform_mode_bits == MODE_FAST) || (cfg.waveform_mode_bits == MODE_PHASE);
    cmp_at_top = (cfg.compare_value == CNT_MAX);
    at_top     = timer_tick && (counter_value == CNT_MAX);
    match      = timer_tick && !match_block && (counter_value == cfg.compare_value);
  end

  always_comb
  begin
    state_next = state_reg;
    if (!pwm_mode)
    begin
      if (match || force_match)
      begin
        case (cfg.compare_output_mode)
          2'h1:    state_next.level = !state_reg.level;
          2'h2:    state_next.level = 1'b0;
          2'h3:    state_next.level = 1'b1;
          default: state_next.level = state_reg.level;
        endcase
      end
    end
    else if (cfg.compare_output_mode[1])
    begin
      // Code 01 is reserved in both PWM modes and leaves the level alone
      if (cmp_at_top)
      begin
        if (at_top)
        begin
          state_next.level = !cfg.compare_output_mode[0];
        end
      end
      else if (cfg.waveform_mode_bits == MODE_FAST)
      begin
        if (at_top)
        begin
          state_next.level = !cfg.compare_output_mode[0];
        end
        else if (match)
        begin
          state_next.level = cfg.compare_output_mode[0];
        end
      end
      else if (match)
      begin
        state_next.level = count_up ? cfg.compare_output_mode[0]
                                    : !cfg.compare_output_mode[0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

endmodule : at8_waveform

/* rtl/at8_timer.sv */
// Top of the 8-bit timer with one compare output, APB registers and optional
// asynchronous timer source sampled from the oscillator input pin.
// Assumes pclk is the io_clock; the oscillator pin is far slower than pclk.
//
// Notes on behaviour
// - Nonzero output mode takes the pin; direction enables
// - Non-PWM codes: off, toggle, clear, set on match
// - Fast PWM: 10 non-inverting, 11 inverting
// - Compare at TOP: ignore match, act at TOP
// - Phase PWM: match action flips with direction
// - Clock select: stop, direct, /8 ... /1024
// - Counter write blocks next timer-clock match
// - Compare register compared continuously with counter
// - External clock enable stops crystal, feeds pin when async selected
// - Async select picks oscillator pin over io_clock
// - Async writes set busy until transferred
// - Counter reads live; compare, control read temp
// - Compare interrupt when both enables and flag
// - Overflow interrupt when both enables and flag
// - Compare flag set on match, cleared by vector/W1C
// - Overflow flag on wrap or phase bottom
// - Prescaler reset bit; async holds until done
// - Sync mode bit keeps prescaler reset set
// - Mode bits: normal, phase PWM, clear-on-match, fast PWM
`timescale 1ns/1ps
module at8_timer
  import at8_pkg::*;
#(
  parameter int ADDR_WIDTH = 12
)
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [ADDR_WIDTH-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  osc_input_pin,
  input  wire logic                  vector_ack_compare,
  input  wire logic                  vector_ack_overflow,
  output logic                       compare_output_pin,
  output logic                       compare_output_oe_n,
  output logic                       pin_override,
  output logic                       crystal_osc_enable,
  output logic                       ext_clock_buffer_enable,
  output logic                       irq_compare,
  output logic                       irq_overflow
);

  typedef struct packed {
    logic [31:0] prdata;
    logic        pslverr;
    at8_ctl_t    ctl;
    at8_ctl_t    ctl_tmp;
    logic [7:0]  cnt;
    logic [7:0]  cnt_tmp;
    logic [7:0]  cmp;
    logic [7:0]  cmp_tmp;
    logic        ext_clock_input_enable;
    logic        async_clock_select;
    logic [2:0]  busy;
    logic [1:0]  irq_enable;
    logic [1:0]  flags;
    logic        timer_sync_mode_bit;
    logic        prescaler_reset_bit;
    logic        pin_dir;
    logic        global_ie;
    logic        count_up;
    logic        match_block;
    logic        force_pulse;
    logic [2:0]  osc_sync;
  } at8_state_t;

  at8_state_t    state_reg;
  at8_state_t    state_next;
  logic [7:0]    reg_index;
  logic          addr_ok;
  logic          wr_access;
  logic          src_tick;
  logic          osc_rise;
  logic          timer_tick;
  logic          match;
  logic          level;
  logic [1:0]    wave_mode;
  at8_wave_cfg_t wave_cfg;
  logic          async_mode;

  // One decode shared by the read and the write paths
  function automatic logic index_mapped(input logic [7:0] idx);
    case (idx)
      IDX_TIMER_CONTROL, IDX_COUNTER_VALUE, IDX_COMPARE_VALUE, IDX_ASYNC_STATUS,
      IDX_IRQ_MASK, IDX_IRQ_FLAGS, IDX_GENERAL_CTL, IDX_PIN_CONTROL:
        index_mapped = 1'b1;
      default:
        index_mapped = 1'b0;
    endcase
  endfunction : index_mapped

  assign reg_index  = paddr[9:2];
  assign addr_ok    = (paddr[1:0] == 2'h0) && (paddr[ADDR_WIDTH-1:10] == '0)
                      && index_mapped(reg_index);
  assign wr_access  = psel && penable && pwrite && addr_ok;
  assign async_mode = state_reg.async_clock_select;

  // Rising edge of the oscillator pin, seen only through the second and third stages
  assign osc_rise = state_reg.osc_sync[1] && !state_reg.osc_sync[2];
  assign src_tick = async_mode ? osc_rise : 1'b1;

  assign wave_mode = {state_reg.ctl.wave_hi, state_reg.ctl.wave_lo};
  assign wave_cfg  = '{waveform_mode_bits:  wave_mode,
                       compare_output_mode: state_reg.ctl.compare_output_mode,
                       compare_value:       state_reg.cmp};

  assign prdata  = state_reg.prdata;
  assign pslverr = psel && penable && state_reg.pslverr;
  assign pready  = psel && penable;

  assign compare_output_pin      = level;
  assign pin_override            = |state_reg.ctl.compare_output_mode;
  assign compare_output_oe_n     = !(pin_override && state_reg.pin_dir);
  // The crystal only runs while the external clock buffer is off
  assign crystal_osc_enable      = async_mode && !state_reg.ext_clock_input_enable;
  assign ext_clock_buffer_enable = async_mode && state_reg.ext_clock_input_enable;
  assign irq_compare  = state_reg.flags[IRQ_COMPARE_BIT] && state_reg.irq_enable[IRQ_COMPARE_BIT]
                        && state_reg.global_ie;
  assign irq_overflow = state_reg.flags[IRQ_OVERFLOW_BIT]
                        && state_reg.irq_enable[IRQ_OVERFLOW_BIT]
                        && state_reg.global_ie;

  at8_prescaler #(
    .WIDTH (PRESCALE_BITS)
  ) u_prescaler (
    .pclk              (pclk),
    .presetn           (presetn),
    .src_tick          (src_tick),
    .clear             (state_reg.prescaler_reset_bit),
    .clock_select_bits (state_reg.ctl.clock_select_bits),
    .timer_tick        (timer_tick)
  );

  at8_waveform u_waveform (
    .pclk          (pclk),
    .presetn       (presetn),
    .timer_tick    (timer_tick),
    .counter_value (state_reg.cnt),
    .count_up      (state_reg.count_up),
    .match_block   (state_reg.match_block),
    .force_match   (state_reg.force_pulse),
    .cfg           (wave_cfg),
    .match         (match),
    .out_level     (level)
  );

  always_comb
  begin
    logic set_overflow;
    set_overflow = 1'b0;
    state_next   = state_reg;
    state_next.osc_sync    = {state_reg.osc_sync[1:0], osc_input_pin};
    state_next.force_pulse = 1'b0;

    // Counting sequence per waveform mode
    if (timer_tick)
    begin
      state_next.match_block = 1'b0;
      case (wave_mode)
        MODE_PHASE:
        begin
          if (state_reg.count_up)
          begin
            if (state_reg.cnt == CNT_MAX)
            begin
              state_next.count_up = 1'b0;
              state_next.cnt      = CNT_MAX - CNT_ONE;
            end
            else
            begin
              state_next.cnt = state_reg.cnt + CNT_ONE;
            end
          end
          else if (state_reg.cnt == CNT_BOTTOM)
          begin
            state_next.count_up = 1'b1;
            state_next.cnt      = CNT_ONE;
            set_overflow        = 1'b1;
          end
          else
          begin
            state_next.cnt = state_reg.cnt - CNT_ONE;
          end
        end
        MODE_CLEAR_MATCH:
        begin
          state_next.count_up = 1'b1;
          state_next.cnt      = (state_reg.cnt == state_reg.cmp) ? CNT_BOTTOM
                                : state_reg.cnt + CNT_ONE;
          set_overflow        = (state_reg.cnt == CNT_MAX);
        end
        default:
        begin
          state_next.count_up = 1'b1;
          state_next.cnt      = state_reg.cnt + CNT_ONE;
          set_overflow        = (state_reg.cnt == CNT_MAX);
        end
      endcase
    end

    // Temporary storage moves into the timer on the next source clock
    if (async_mode && src_tick)
    begin
      if (state_reg.busy[BUSY_COUNTER_BIT])
      begin
        state_next.cnt         = state_reg.cnt_tmp;
        state_next.match_block = 1'b1;
      end
      if (state_reg.busy[BUSY_COMPARE_BIT])
      begin
        state_next.cmp = state_reg.cmp_tmp;
      end
      if (state_reg.busy[BUSY_CONTROL_BIT])
      begin
        state_next.ctl         = state_reg.ctl_tmp;
        // The incoming mode decides, since the force acts after the transfer
        state_next.force_pulse = state_reg.ctl_tmp.force_match && !state_reg.ctl_tmp.wave_lo;
      end
      state_next.busy = 3'h0;
    end

    // Prescaler reset ends at once with io_clock, at a source edge in async mode, and never while the sync mode bit is set
    if (state_reg.prescaler_reset_bit && !state_reg.timer_sync_mode_bit
        && (!async_mode || src_tick))
    begin
      state_next.prescaler_reset_bit = 1'b0;
    end

    // Flag clears first so that a same-cycle hardware set wins
    if (vector_ack_compare)
    begin
      state_next.flags[IRQ_COMPARE_BIT] = 1'b0;
    end
    if (vector_ack_overflow)
    begin
      state_next.flags[IRQ_OVERFLOW_BIT] = 1'b0;
    end

    // Read data is captured in the setup cycle so prdata comes from a flop
    if (psel && !penable)
    begin
      state_next.pslverr = !addr_ok;
      state_next.prdata  = 32'h0000_0000;
      case (reg_index)
        IDX_TIMER_CONTROL: state_next.prdata[7:0] = {1'b0, state_reg.ctl_tmp[6:0]};
        IDX_COUNTER_VALUE: state_next.prdata[7:0] = state_reg.cnt;
        IDX_COMPARE_VALUE: state_next.prdata[7:0] = state_reg.cmp_tmp;
        IDX_ASYNC_STATUS:  state_next.prdata[7:0] = {3'h0, state_reg.ext_clock_input_enable,
                                                     state_reg.async_clock_select,
                                                     state_reg.busy};
        IDX_IRQ_MASK:      state_next.prdata[7:0] = {6'h00, state_reg.irq_enable};
        IDX_IRQ_FLAGS:     state_next.prdata[7:0] = {6'h00, state_reg.flags};
        IDX_GENERAL_CTL:   state_next.prdata[7:0] = {state_reg.timer_sync_mode_bit, 5'h00,
                                                     state_reg.prescaler_reset_bit, 1'b0};
        IDX_PIN_CONTROL:   state_next.prdata[7:0] = {6'h00, state_reg.global_ie,
                                                     state_reg.pin_dir};
        default:           state_next.prdata[7:0] = RESET_BYTE;
      endcase
    end

    if (wr_access)
    begin
      case (reg_index)
        IDX_TIMER_CONTROL:
        begin
          state_next.ctl_tmp = {1'b0, pwdata[6:0]};
          if (async_mode)
          begin
            // Force bit rides along and acts at transfer time
            state_next.ctl_tmp.force_match      = pwdata[7];
            state_next.busy[BUSY_CONTROL_BIT]   = 1'b1;
          end
          else
          begin
            state_next.ctl         = {1'b0, pwdata[6:0]};
            state_next.force_pulse = pwdata[7] && !pwdata[6];
          end
        end
        IDX_COUNTER_VALUE:
        begin
          state_next.cnt_tmp = pwdata[7:0];
          if (async_mode)
          begin
            state_next.busy[BUSY_COUNTER_BIT] = 1'b1;
          end
          else
          begin
            state_next.cnt         = pwdata[7:0];
            state_next.match_block = 1'b1;
          end
        end
        IDX_COMPARE_VALUE:
        begin
          state_next.cmp_tmp = pwdata[7:0];
          if (async_mode)
          begin
            state_next.busy[BUSY_COMPARE_BIT] = 1'b1;
          end
          else
          begin
            state_next.cmp = pwdata[7:0];
          end
        end
        IDX_ASYNC_STATUS:
        begin
          state_next.ext_clock_input_enable = pwdata[ASYNC_EXT_CLK_BIT];
          state_next.async_clock_select     = pwdata[ASYNC_SELECT_BIT];
        end
        IDX_IRQ_MASK:
        begin
          state_next.irq_enable = pwdata[1:0];
        end
        IDX_IRQ_FLAGS:
        begin
          state_next.flags = state_next.flags & ~pwdata[1:0];
        end
        IDX_GENERAL_CTL:
        begin
          state_next.timer_sync_mode_bit = pwdata[GEN_SYNC_MODE_BIT];
          if (pwdata[GEN_PRESCALE_RST])
          begin
            state_next.prescaler_reset_bit = 1'b1;
          end
        end
        IDX_PIN_CONTROL:
        begin
          state_next.pin_dir   = pwdata[PIN_DIR_BIT];
          state_next.global_ie = pwdata[PIN_GLOBAL_IE_BIT];
        end
        default:
        begin
          state_next.pin_dir = state_reg.pin_dir;
        end
      endcase
    end

    // Hardware sets last: an event in the clearing cycle is kept
    if (match)
    begin
      state_next.flags[IRQ_COMPARE_BIT] = 1'b1;
    end
    if (set_overflow)
    begin
      state_next.flags[IRQ_OVERFLOW_BIT] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

endmodule : at8_timer

/* sim/at8_timer_assertions.sv */
// Port-level checker for the 8-bit compare timer.
// Assumes it is bound into at8_timer and sees only that module's ports.
`timescale 1ns/1ps
module at8_timer_chk
  import at8_pkg::*;
#(
  parameter int ADDR_WIDTH = 12
)
(
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0]           pwdata,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire logic                  osc_input_pin,
  input wire logic                  vector_ack_compare,
  input wire logic                  vector_ack_overflow,
  input wire logic                  compare_output_pin,
  input wire logic                  compare_output_oe_n,
  input wire logic                  pin_override,
  input wire logic                  crystal_osc_enable,
  input wire logic                  ext_clock_buffer_enable,
  input wire logic                  irq_compare,
  input wire logic                  irq_overflow
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_acc;
    psel && penable;
  endsequence
  property p_rdy;
    s_setup ##1 s_acc |-> pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready missing in access");
  property p_idle;
    !penable |-> !pready && !pslverr;
  endproperty
  a_idle: assert property (p_idle) else $error("response outside access");
  property p_hi;
    s_acc ##0 !pwrite |-> prdata[31:8] == 24'h000000;
  endproperty
  a_hi: assert property (p_hi) else $error("upper read bits set");
  property p_mis;
    s_acc ##0 (paddr[1:0] != 2'h0) |-> pslverr;
  endproperty
  a_mis: assert property (p_mis) else $error("misaligned not refused");
  property p_oe;
    !pin_override |-> compare_output_oe_n;
  endproperty
  a_oe: assert property (p_oe) else $error("pin driven while off");
  property p_osc;
    crystal_osc_enable |-> !ext_clock_buffer_enable;
  endproperty
  a_osc: assert property (p_osc) else $error("crystal and buffer both on");
  property p_cfall;
    $fell(irq_compare) |-> $past(vector_ack_compare) || ($past(penable) && $past(pwrite));
  endproperty
  a_cfall: assert property (p_cfall) else $error("compare request lost");
  property p_ofall;
    $fell(irq_overflow) |-> $past(vector_ack_overflow) || ($past(penable) && $past(pwrite));
  endproperty
  a_ofall: assert property (p_ofall) else $error("overflow request lost");
endmodule : at8_timer_chk

bind at8_timer at8_timer_chk #(.ADDR_WIDTH(ADDR_WIDTH)) u_chk (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .osc_input_pin,
  .vector_ack_compare, .vector_ack_overflow, .compare_output_pin, .compare_output_oe_n,
  .pin_override, .crystal_osc_enable, .ext_clock_buffer_enable, .irq_compare, .irq_overflow);

/* sim/at8_osc_model.sv */
// Oscillator or external clock seen on the timer's oscillator pin.
// Assumes run gates it, so the bench can hold the pin still on purpose.
`timescale 1ns/1ps
module at8_osc_model #(
  parameter int HALF = 8
)
(
  input  wire logic pclk,
  input  wire logic xtal_en,
  input  wire logic ext_en,
  input  wire logic run,
  output logic      osc
);
  int n = 0;
  initial osc = 1'b0;
  // Only runs when the device enables crystal or buffer
  always @(posedge pclk)
    if ((xtal_en || ext_en) && run)
    begin
      n <= (n == HALF - 1) ? 0 : n + 1;
      if (n == HALF - 1)
        osc <= ~osc;
    end
endmodule : at8_osc_model

/* sim/tb.sv */
// Self-checking bench for the 8-bit compare timer over APB.
// Assumes the oscillator model drives the oscillator pin.
`timescale 1ns/1ps
module tb
  import at8_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, run = 0;
  logic vector_ack_compare = 0, vector_ack_overflow = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, s = 32'hF96A;
  logic pready, pslverr, osc_input_pin, compare_output_pin, compare_output_oe_n;
  logic pin_override, crystal_osc_enable, ext_clock_buffer_enable;
  logic irq_compare, irq_overflow;
  logic [32:0] exp_q[$];
  logic [32:0] e;
  int errors = 0, num_checks = 0;
  logic [3:0] codes[3] = '{4'h3, 4'h2, 4'h1};
  logic pins[3] = '{1'b1, 1'b0, 1'b1};
  always #12.5 pclk = ~pclk;
  at8_timer #(.ADDR_WIDTH(12)) DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .osc_input_pin, .vector_ack_compare,
    .vector_ack_overflow, .compare_output_pin, .compare_output_oe_n, .pin_override,
    .crystal_osc_enable, .ext_clock_buffer_enable, .irq_compare, .irq_overflow);
  at8_osc_model u_osc (.pclk, .xtal_en(crystal_osc_enable),
    .ext_en(ext_clock_buffer_enable), .run, .osc(osc_input_pin));
  task automatic chk(input logic [32:0] v, input logic [32:0] x);
    num_checks++;
    if (v !== x)
    begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, v, x);
    end
  endtask : chk
  task automatic end_of_test;
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  // Held request until pready, then an idle cycle so no signal is set twice
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                     input logic [32:0] x);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
    if (!w)
      exp_q.push_back(x);
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (!pready);
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    apb(1, {2'b00, i, 2'b00}, d, 33'h0);
  endtask : wr
  task automatic rd(input logic [7:0] i, input logic [7:0] d);
    apb(0, {2'b00, i, 2'b00}, 8'h00, {25'h0, d});
  endtask : rd
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick
  // Read data is judged at the sampling edge of each completed read
  always @(posedge pclk)
    if (psel && penable && pready && !pwrite)
    begin
      e = exp_q.pop_front();
      chk({pslverr, prdata}, e);
    end
  initial
  begin
    #100000ns;
    errors++;
    end_of_test();
  end
  initial
  begin
    tick(20);
    presetn <= 1;
    tick(1);
    rd(IDX_ASYNC_STATUS, 8'h00);
    rd(IDX_TIMER_CONTROL, 8'h00);
    apb(0, 12'h004, 8'h00, {1'b1, 32'h0});
    apb(0, 12'h2C5, 8'h00, {1'b1, 32'h0});
    repeat (4)
    begin
      s = lfsr(s);
      wr(IDX_COMPARE_VALUE, s[7:0]);
      rd(IDX_COMPARE_VALUE, s[7:0]);
    end
    wr(IDX_COUNTER_VALUE, 8'h5A);
    rd(IDX_COUNTER_VALUE, 8'h5A);
    wr(IDX_GENERAL_CTL, 8'h02);
    rd(IDX_GENERAL_CTL, 8'h00);
    wr(IDX_GENERAL_CTL, 8'h82);
    rd(IDX_GENERAL_CTL, 8'h82);
    wr(IDX_GENERAL_CTL, 8'h00);
    wr(IDX_PIN_CONTROL, 8'h03);
    wr(IDX_IRQ_MASK, 8'h03);
    wr(IDX_COMPARE_VALUE, 8'hF5);
    for (int i = 0; i < 3; i++)
    begin
      wr(IDX_COUNTER_VALUE, 8'hF0);
      wr(IDX_TIMER_CONTROL, {codes[i], 4'h1});
      tick(10);
      wr(IDX_TIMER_CONTROL, {codes[i], 4'h0});
      chk({32'h0, compare_output_pin}, {32'h0, pins[i]});
    end
    chk({32'h0, compare_output_oe_n}, 33'h0);
    chk({32'h0, pin_override}, 33'h1);
    chk({32'h0, irq_compare}, 33'h1);
    vector_ack_compare <= 1;
    tick(1);
    vector_ack_compare <= 0;
    tick(2);
    chk({32'h0, irq_compare}, 33'h0);
    wr(IDX_COUNTER_VALUE, 8'hFE);
    wr(IDX_TIMER_CONTROL, 8'h01);
    tick(5);
    wr(IDX_TIMER_CONTROL, 8'h00);
    chk({32'h0, irq_overflow}, 33'h1);
    rd(IDX_IRQ_FLAGS, 8'h01);
    vector_ack_overflow <= 1;
    tick(1);
    vector_ack_overflow <= 0;
    tick(2);
    chk({32'h0, irq_overflow}, 33'h0);
    wr(IDX_COUNTER_VALUE, 8'hF0);
    wr(IDX_TIMER_CONTROL, 8'h79);
    tick(30);
    wr(IDX_TIMER_CONTROL, 8'h78);
    chk({32'h0, compare_output_pin}, 33'h0);
    wr(IDX_COUNTER_VALUE, 8'hF0);
    wr(IDX_TIMER_CONTROL, 8'h61);
    tick(30);
    wr(IDX_TIMER_CONTROL, 8'h60);
    chk({32'h0, compare_output_pin}, 33'h1);
    // Prescaler restarted first, so exactly two divide-by-8 ticks land
    wr(IDX_COUNTER_VALUE, 8'h00);
    wr(IDX_GENERAL_CTL, 8'h02);
    wr(IDX_TIMER_CONTROL, 8'h02);
    tick(17);
    wr(IDX_TIMER_CONTROL, 8'h00);
    rd(IDX_COUNTER_VALUE, 8'h02);
    rd(IDX_IRQ_FLAGS, 8'h03);
    wr(IDX_IRQ_FLAGS, 8'h03);
    rd(IDX_IRQ_FLAGS, 8'h00);
    wr(IDX_TIMER_CONTROL, 8'h00);
    wr(IDX_ASYNC_STATUS, 8'h08);
    chk({32'h0, crystal_osc_enable}, 33'h1);
    wr(IDX_COMPARE_VALUE, 8'h33);
    rd(IDX_ASYNC_STATUS, 8'h0A);
    rd(IDX_COMPARE_VALUE, 8'h33);
    run <= 1;
    tick(200);
    rd(IDX_ASYNC_STATUS, 8'h08);
    // External clock enabled with async off, then async selected again
    wr(IDX_ASYNC_STATUS, 8'h10);
    chk({31'h0, ext_clock_buffer_enable, crystal_osc_enable}, 33'h0);
    wr(IDX_ASYNC_STATUS, 8'h18);
    chk({31'h0, ext_clock_buffer_enable, crystal_osc_enable}, 33'h2);
    end_of_test();
  end
endmodule : tb
